// ### hw/dma_cmd_ctrl.sv
// DMA command launch, handshake configuration and transfer sequencing
// What this block does
// - In target transfers the end polarity bit picks the active end level; initiator transfers ignore the end input.
// - Initiator select is 0 for target transfers with external strobes, 1 for initiator transfers.
// - Separate polarity bits set the active level of acknowledge, request, write and read strobes.
// - Disk multiword transfers need disk select 1, initiator select 0, and take their timing from the mode field.
// - A three-bit field selects the programmed-I/O strobe timing.
// - The data bus is released after reset until a command drives it; control outputs are always driven.
// - Writing the 8-bit command register starts activity; it reads all ones and resets to all ones.
// - A programmed-I/O read moves exactly one 16-bit word whatever the width.
// - Command 00 in target mode captures bus data into the buffer on external write strobes.
// - Command 01 in target mode drives buffer data on the bus on external read strobes.
// - Commands 00 and 01 are refused while configured as initiator.
// - With the counter on, each transfer decrements it; at zero the complete flag and interrupt rise; end ends early.
// - In end-only mode a target transfer ends on external end, short packet, or stop command; initiator transfers still count.
// - Commands 06 and 07 run initiator or disk transfers, 06 into the buffer and 07 out of it.
// - A two-bit strobe mode chooses which of acknowledge and strobes qualifies data.
`timescale 1ns/1ps
`default_nettype none
module dma_cmd_ctrl #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic usbBusReset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // DMA pins
  input wire dma_pkg::pin_in_t pinIn,
  output dma_pkg::pin_out_t pinOut,
  // Endpoint buffer side
  output logic toBufValid,
  output logic [15:0] toBufData,
  input wire logic toBufReady,
  input wire logic [15:0] fromBufData,
  input wire logic fromBufValid,
  output logic fromBufReady,
  input wire logic shortPacket,
  // Interrupt
  output logic irq
);
  import dma_pkg::*;
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
    $error("dma_cmd_ctrl: CNT_W must be 2 to 32");
  end
  typedef struct packed {
    xfer_t fsm;
    cfg_t cfg;
    logic [CNT_W-1:0] count;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [7:0] cmdReg;
    logic dWrite;
    logic [7:0] dAddr;
    logic [31:0] rdata;
    pin_in_t sync1;
    pin_in_t sync2;
    logic prevQual;
    logic dataOe;
    logic [15:0] dataOut;
    logic toBufValid;
    logic [15:0] toBufData;
    logic [1:0] strbDly;
    logic [15:0] rdHold;
  } state_t;

  state_t q, n;
  logic cmdWr, step, eotAct, qual, rise, fall, tmrStart, tmrStrobe, tmrBusy, tmrDone, pop, strb, ackA, reqA, cntOn;
  logic [ST_W-1:0] set, clr;
  logic [7:0] actCyc;
  // Active level of a pin under its polarity bit; also maps active back to pin level
  function automatic logic lvl(input logic v, input logic pol);
    return v ~^ pol;
  endfunction

  // Which handshake lines qualify a data beat
  function automatic logic qualify(input logic [1:0] mode, input logic ack, input logic strb);
    case (mode)
      2'h0: return strb;
      2'h1: return ack;
      default: return ack & strb;
    endcase
  endfunction

  // Byte lane handling for the configured width and order
  function automatic logic [15:0] order(input logic [15:0] d, input cfg_t c);
    if (!c.wide) return {8'h00, d[7:0]};
    if (c.byteOrderSelect == ORDER_SWAP) return {d[7:0], d[15:8]};
    return d;
  endfunction
  // Strobe timing; a programmed read starts from idle, so only initiator states take disk timing
  assign actCyc = q.cfg.diskTransferSelect && (q.fsm == INI_IN || q.fsm == INI_OUT) ?
      MW_ACT_BASE - {6'h00, q.cfg.multiwordTiming} :
      PIO_ACT_BASE - {5'h00, q.cfg.programmedIoTimingSelect};
  dma_strobe_timer #(.CW(8)) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(tmrStart),
    .actCyc(actCyc),
    .recCyc(REC_CYC),
    .strobe(tmrStrobe),
    .busy(tmrBusy),
    .done(tmrDone)
  );
  // Whole next-state computation
  always_comb begin
    n = q;
    set = '0;
    clr = '0;
    cmdWr = 1'b0;
    step = 1'b0;
    tmrStart = 1'b0;
    pop = 1'b0;
    n.sync1 = pinIn;
    n.sync2 = q.sync1;
    ackA = lvl(q.sync2.dack, q.cfg.acknowledgePolarity);
    reqA = lvl(q.sync2.dreq, q.cfg.requestPolarity);
    strb = (q.fsm == TGT_IN) ? lvl(q.sync2.diow, q.cfg.writeStrobePolarity) :
        lvl(q.sync2.dior, q.cfg.readStrobePolarity);
    qual = qualify(q.cfg.strobeMode, ackA, strb);
    n.prevQual = qual;
    rise = qual & ~q.prevQual;
    fall = ~qual & q.prevQual;
    eotAct = lvl(q.sync2.eot, q.cfg.transferEndPolarity);
    cntOn = (q.fsm == INI_IN) || (q.fsm == INI_OUT) || !q.cfg.counterDisable;
    n.toBufValid = q.toBufValid & ~toBufReady;
    n.dataOut = order(fromBufData, q.cfg);
    n.strbDly = {q.strbDly[0], tmrStrobe}; // Delayed like the pins, so reads latch while data still stands
    if (q.strbDly[1] && !q.strbDly[0]) n.rdHold = q.sync2.data;
    // Address phase: capture and prepare read data, zero wait states
    n.dWrite = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.dWrite = hwrite;
      n.dAddr = haddr[7:0];
      n.rdata = '0;
      case (haddr[7:0])
        ADDR_CMD: n.rdata = 32'h0000_00ff;
        ADDR_COUNT: n.rdata[CNT_W-1:0] = q.count;
        ADDR_CFG: n.rdata[CFG_W-1:0] = q.cfg;
        ADDR_STATUS: n.rdata[ST_W-1:0] = q.status;
        ADDR_MASK: n.rdata[ST_W-1:0] = q.mask;
        ADDR_STATE: n.rdata[4:0] = {q.fsm, q.dataOe, tmrBusy};
        default: n.rdata = '0;
      endcase
    end
    // Data phase writes
    if (q.dWrite) begin
      case (q.dAddr)
        ADDR_CMD: cmdWr = 1'b1;
        ADDR_COUNT: n.count = hwdata[CNT_W-1:0];
        ADDR_CFG: n.cfg = hwdata[CFG_W-1:0];
        ADDR_STATUS: clr = hwdata[ST_W-1:0];
        ADDR_MASK: n.mask = hwdata[ST_W-1:0];
        default: ;
      endcase
    end
    // Transfer engine
    case (q.fsm)
      TGT_IN: begin
        if (rise && !q.toBufValid) begin
          n.toBufData = order(q.sync2.data, q.cfg);
          n.toBufValid = 1'b1;
          step = 1'b1;
        end
      end
      TGT_OUT: begin
        if (fall && fromBufValid) begin
          pop = 1'b1;
          step = 1'b1;
        end
      end
      INI_IN: begin
        if (tmrDone) begin
          n.toBufData = order(q.rdHold, q.cfg);
          n.toBufValid = 1'b1;
          step = 1'b1;
        end else if (!tmrBusy && !q.toBufValid && (!q.cfg.diskTransferSelect || reqA)) begin
          tmrStart = 1'b1;
        end
      end
      INI_OUT: begin
        if (tmrDone) begin
          pop = 1'b1;
          step = 1'b1;
        end else if (!tmrBusy && fromBufValid && (!q.cfg.diskTransferSelect || reqA)) begin
          tmrStart = 1'b1;
        end
      end
      PIO_RD: begin
        if (tmrDone) begin
          n.toBufData = q.rdHold;
          n.toBufValid = 1'b1;
          set[ST_PIO] = 1'b1;
          n.fsm = IDLE;
        end
      end
      default: ;
    endcase
    // Counting and termination
    if (step && cntOn) begin
      n.count = q.count - CNT_W'(1);
      if (q.count == CNT_W'(1)) begin
        set[ST_DONE] = 1'b1;
        n.fsm = IDLE;
      end
    end
    if ((q.fsm == TGT_IN || q.fsm == TGT_OUT) && eotAct) begin
      set[ST_EXT_EOT] = 1'b1;
      n.fsm = IDLE;
    end
    if ((q.fsm == TGT_IN || q.fsm == TGT_OUT) && q.cfg.counterDisable && shortPacket) begin
      set[ST_INT_EOT] = 1'b1;
      n.fsm = IDLE;
    end
    // Command launch
    if (cmdWr) begin
      n.cmdReg = hwdata[7:0];
      case (hwdata[7:0])
        CMD_TGT_IN, CMD_TGT_OUT: begin
          if (q.fsm == IDLE && !q.cfg.initiatorSelect && !q.cfg.diskTransferSelect) begin
            n.fsm = hwdata[0] ? TGT_OUT : TGT_IN;
          end
        end
        CMD_INI_IN, CMD_INI_OUT: begin
          if (q.fsm == IDLE && (q.cfg.initiatorSelect ^ q.cfg.diskTransferSelect)) begin
            n.fsm = hwdata[0] ? INI_OUT : INI_IN;
          end
        end
        CMD_PIO_READ: begin
          if (q.fsm == IDLE) begin
            n.fsm = PIO_RD;
            tmrStart = 1'b1;
          end
        end
        CMD_INI_STOP: begin
          if (q.fsm == INI_IN || q.fsm == INI_OUT) begin
            n.fsm = IDLE;
            set[ST_STOP] = 1'b1;
          end
        end
        CMD_GEN_STOP: begin
          if (q.fsm == TGT_IN || q.fsm == TGT_OUT) begin
            n.fsm = IDLE;
            set[ST_STOP] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Bus drive only while sending, released otherwise
    n.dataOe = (n.fsm == TGT_OUT) || (n.fsm == INI_OUT);
    // Sticky status, a new event beats a same-cycle clear
    n.status = (q.status & ~clr) | set;
    if (usbBusReset) begin
      n.cmdReg = CMD_RESET;
      n.fsm = IDLE;
      n.dataOe = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{fsm: IDLE, cfg: CFG_RESET, count: '0, status: STATUS_RESET, mask: '0,
             cmdReg: CMD_RESET, dWrite: 1'b0, dAddr: '0, rdata: '0, sync1: '0,
             sync2: '0, prevQual: 1'b0, dataOe: 1'b0, dataOut: '0,
             toBufValid: 1'b0, toBufData: '0, strbDly: '0, rdHold: '0};
    end else begin
      q <= n;
    end
  end
  // Bus answers and pins; idle handshake outputs sit at their inactive level
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign pinOut.dreq = lvl(((q.fsm == TGT_IN) && !q.toBufValid) ||
      ((q.fsm == TGT_OUT) && fromBufValid), q.cfg.requestPolarity);
  assign pinOut.dack = lvl(tmrStrobe && q.cfg.strobeMode != 2'h0 &&
      (q.fsm == INI_IN || q.fsm == INI_OUT), q.cfg.acknowledgePolarity);
  assign pinOut.dior = lvl(tmrStrobe && (q.fsm == INI_IN || q.fsm == PIO_RD), q.cfg.readStrobePolarity);
  assign pinOut.diow = lvl(tmrStrobe && q.fsm == INI_OUT, q.cfg.writeStrobePolarity);
  assign pinOut.dataOe = q.dataOe;
  assign pinOut.data = q.dataOut;
  assign toBufValid = q.toBufValid;
  assign toBufData = q.toBufData;
  assign fromBufReady = pop;
  assign irq = |(q.status & q.mask);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_cmdReadsOnes;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ADDR_CMD |=> hrdata == 32'h0000_00ff;
  endproperty
  a_cmdReadsOnes: assert property (p_cmdReadsOnes) else $error("command register did not read ones");
  property p_busReleased;
    (q.fsm == IDLE || q.fsm == TGT_IN || q.fsm == INI_IN || q.fsm == PIO_RD) |-> !pinOut.dataOe;
  endproperty
  a_busReleased: assert property (p_busReleased) else $error("data bus driven while not sending");
  property p_reservedIgnored;
    cmdWr && q.fsm == IDLE && hwdata[7:0] inside {[8'h02:8'h05]} && !usbBusReset |=> q.fsm == IDLE && !q.dataOe;
  endproperty
  a_reservedIgnored: assert property (p_reservedIgnored) else $error("reserved command acted");
  property p_targetOnly;
    cmdWr && q.cfg.initiatorSelect && hwdata[7:1] == 7'h00 && q.fsm == IDLE |=> q.fsm == IDLE;
  endproperty
  a_targetOnly: assert property (p_targetOnly) else $error("target command ran as initiator");
  property p_swap;
    q.fsm == TGT_IN && rise && !q.toBufValid && q.cfg.wide && q.cfg.byteOrderSelect == ORDER_SWAP
        |=> toBufData == {$past(q.sync2.data[7:0]), $past(q.sync2.data[15:8])};
  endproperty
  a_swap: assert property (p_swap) else $error("bytes not swapped");
  property p_countZeroDone;
    step && !q.cfg.counterDisable && q.count == CNT_W'(1) && !cmdWr |=> q.status[ST_DONE] && q.fsm == IDLE;
  endproperty
  a_countZeroDone: assert property (p_countZeroDone) else $error("counter end not flagged");
  property p_extEnd;
    (q.fsm == TGT_IN || q.fsm == TGT_OUT) && eotAct && !cmdWr |=> q.fsm == IDLE ##0 q.status[ST_EXT_EOT];
  endproperty
  a_extEnd: assert property (p_extEnd) else $error("external end not honoured");
  property p_pioOneWord;
    q.fsm == PIO_RD && tmrDone |=> q.fsm == IDLE && toBufValid && q.status[ST_PIO];
  endproperty
  a_pioOneWord: assert property (p_pioOneWord) else $error("programmed read did not finish one word");
endmodule // dma_cmd_ctrl
`default_nettype wire

// ### hw/dma_pkg.sv
// Shared constants and types of the DMA command and handshake block
package dma_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h30;
  localparam logic [7:0] ADDR_COUNT = 8'h34;
  localparam logic [7:0] ADDR_CFG = 8'h38;
  localparam logic [7:0] ADDR_STATUS = 8'h3c;
  localparam logic [7:0] ADDR_MASK = 8'h40;
  localparam logic [7:0] ADDR_STATE = 8'h44;
  // Command codes
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_TGT_IN = 8'h00;
  localparam logic [7:0] CMD_TGT_OUT = 8'h01;
  localparam logic [7:0] CMD_INI_IN = 8'h06;
  localparam logic [7:0] CMD_INI_OUT = 8'h07;
  localparam logic [7:0] CMD_PIO_READ = 8'h0a;
  localparam logic [7:0] CMD_INI_STOP = 8'h12;
  localparam logic [7:0] CMD_GEN_STOP = 8'h13;
  localparam logic [1:0] ORDER_SWAP = 2'h1;
  // Status and mask bit positions
  localparam int ST_DONE = 0;
  localparam int ST_EXT_EOT = 1;
  localparam int ST_INT_EOT = 2;
  localparam int ST_STOP = 3;
  localparam int ST_PIO = 4;
  localparam int ST_W = 5;
  localparam logic [ST_W-1:0] STATUS_RESET = 5'h00;
  // Strobe timing in cycles, faster modes subtract the mode number
  localparam logic [7:0] MW_ACT_BASE = 8'h08;
  localparam logic [7:0] PIO_ACT_BASE = 8'h0c;
  localparam logic [7:0] REC_CYC = 8'h02;

  typedef struct packed {
    logic [1:0] strobeMode;
    logic [2:0] programmedIoTimingSelect;
    logic [1:0] multiwordTiming;
    logic diskTransferSelect;
    logic initiatorSelect;
    logic readStrobePolarity;
    logic writeStrobePolarity;
    logic requestPolarity;
    logic acknowledgePolarity;
    logic transferEndPolarity;
    logic [1:0] byteOrderSelect;
    logic counterDisable;
    logic wide;
  } cfg_t;
  localparam int CFG_W = $bits(cfg_t);
  localparam cfg_t CFG_RESET = '0;

  typedef struct packed {
    logic dreq;
    logic dack;
    logic dior;
    logic diow;
    logic eot;
    logic [15:0] data;
  } pin_in_t;

  typedef struct packed {
    logic dreq;
    logic dack;
    logic dior;
    logic diow;
    logic dataOe;
    logic [15:0] data;
  } pin_out_t;

  typedef enum logic [2:0] {IDLE, TGT_IN, TGT_OUT, INI_IN, INI_OUT, PIO_RD} xfer_t;
  typedef enum logic [1:0] {T_IDLE, T_ACT, T_REC} tphase_t;
endpackage

// ### hw/dma_strobe_timer.sv
// Strobe timer: one active phase then one recovery phase per start pulse
`timescale 1ns/1ps
`default_nettype none
module dma_strobe_timer #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic [CW-1:0] actCyc,
  input wire logic [CW-1:0] recCyc,
  // Status
  output logic strobe,
  output logic busy,
  output logic done
);
  import dma_pkg::*;

  if (CW < 2) begin : g_bad_width
    $error("dma_strobe_timer: CW must be at least 2");
  end

  typedef struct packed {
    tphase_t phase;
    logic [CW-1:0] cnt;
    logic done;
  } tstate_t;

  tstate_t q, n;

  // Phase sequencing, a zero count still lasts one cycle
  always_comb begin
    n = q;
    n.done = 1'b0;
    case (q.phase)
      T_IDLE: begin
        if (start) begin
          n.phase = T_ACT;
          n.cnt = actCyc;
        end
      end
      T_ACT: begin
        if (q.cnt <= CW'(1)) begin
          n.phase = T_REC;
          n.cnt = recCyc;
        end else begin
          n.cnt = q.cnt - CW'(1);
        end
      end
      T_REC: begin
        if (q.cnt <= CW'(1)) begin
          n.phase = T_IDLE;
          n.done = 1'b1;
        end else begin
          n.cnt = q.cnt - CW'(1);
        end
      end
      default: n.phase = T_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{phase: T_IDLE, cnt: '0, done: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign strobe = (q.phase == T_ACT);
  assign busy = (q.phase != T_IDLE);
  assign done = q.done;
endmodule // dma_strobe_timer
`default_nettype wire

// ### tb/dma_ext_ctrl.sv
// Model of the external DMA controller facing the block's DMA pins
`timescale 1ns/1ps
`default_nettype none
module dma_ext_ctrl (
  // Clock
  input wire logic sys_clk,
  // Device pins
  input wire dma_pkg::pin_out_t pinOut,
  output dma_pkg::pin_in_t pinIn,
  // Polarity set-up and answer word
  input wire logic writePol,
  input wire logic readPol,
  input wire logic reqPol,
  input wire logic ackPol,
  input wire logic eotPol,
  input wire logic [15:0] rdWord
);
  import dma_pkg::*;
  logic wrAct, rdAct, eotAct, drive, devReads;
  int waitFails;
  logic [15:0] drvData, idleData;
  initial begin
    wrAct = 1'b0;
    rdAct = 1'b0;
    eotAct = 1'b0;
    drive = 1'b0;
    drvData = 16'h0000;
    waitFails = 0;
    idleData = 16'h5a5a;
  end
  // Undriven lanes toggle every cycle so stale data never looks valid
  always @(posedge sys_clk) idleData <= ~idleData;
  // A read strobe from the device asks this side for a word
  assign devReads = (pinOut.dior === readPol);
  assign pinIn.data = pinOut.dataOe ? pinOut.data : (devReads ? rdWord : (drive ? drvData : idleData));
  // Strobes at their programmed levels
  assign pinIn.diow = wrAct ? writePol : ~writePol;
  assign pinIn.dior = rdAct ? readPol : ~readPol;
  assign pinIn.eot = eotAct ? eotPol : ~eotPol;
  assign pinIn.dack = ~ackPol;
  assign pinIn.dreq = ~reqPol;
  // Wait for a request, then one write strobe with data set up and held around it
  task automatic writeWord(input logic [15:0] w);
    int k;
    for (k = 0; k < 100 && pinOut.dreq !== reqPol; k++) @(posedge sys_clk);
    if (pinOut.dreq !== reqPol) waitFails++;
    @(posedge sys_clk);
    drvData <= w;
    drive <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wrAct <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wrAct <= 1'b0;
    repeat (3) @(posedge sys_clk);
    drive <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // One read strobe; the word is taken at the end of the active phase
  task automatic readWord(output logic [15:0] w);
    int k;
    for (k = 0; k < 100 && pinOut.dreq !== reqPol; k++) @(posedge sys_clk);
    if (pinOut.dreq !== reqPol) waitFails++;
    @(posedge sys_clk);
    rdAct <= 1'b1;
    repeat (4) @(posedge sys_clk);
    w = pinIn.data;
    rdAct <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Early end of a target transfer
  task automatic endTransfer();
    @(posedge sys_clk);
    eotAct <= 1'b1;
    repeat (4) @(posedge sys_clk);
    eotAct <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule // dma_ext_ctrl
`default_nettype wire

// ### tb/dma_cmd_ctrl_tb.sv
// Self-checking testbench of the DMA command and handshake block
`timescale 1ns/1ps
`default_nettype none
module dma_cmd_ctrl_tb;
  import dma_pkg::*;
  logic sys_clk, reset_n, usbBusReset, hsel, hwrite, toBufReady, fromBufValid, shortPacket;
  logic hreadyout, hresp, toBufValid, fromBufReady, irq, wPol, rPol, qPol, aPol, ePol;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] fromBufData, toBufData, rdWord, w16;
  logic [15:0] got[$];
  pin_in_t pinIn;
  pin_out_t pinOut;
  int miscompares, samples_checked, diorCycles, c, pops;
  dma_cmd_ctrl #(.CNT_W(32)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .usbBusReset(usbBusReset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pinIn(pinIn),
    .pinOut(pinOut), .toBufValid(toBufValid), .toBufData(toBufData), .toBufReady(toBufReady),
    .fromBufData(fromBufData), .fromBufValid(fromBufValid), .fromBufReady(fromBufReady),
    .shortPacket(shortPacket), .irq(irq));
  dma_ext_ctrl ext (.sys_clk(sys_clk), .pinOut(pinOut), .pinIn(pinIn), .writePol(wPol), .readPol(rPol),
    .reqPol(qPol), .ackPol(aPol), .eotPol(ePol), .rdWord(rdWord));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Words handed to the endpoint buffer, and device read-strobe length
  always @(posedge sys_clk) begin
    if (toBufValid === 1'b1 && toBufReady) got.push_back(toBufData);
    if (pinOut.dior === rPol) diorCycles++;
    if (fromBufReady === 1'b1) pops++;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One single AHB word transfer; hready is sampled at each phase's closing edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    htrans <= 2'h2;
    haddr <= {24'h00, a};
    hwrite <= wr;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) begin miscompares++; report_and_stop(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask
  task automatic waitWords(input int n);
    int k;
    for (k = 0; k < 300 && got.size() < n; k++) @(posedge sys_clk);
    if (got.size() < n) begin miscompares++; report_and_stop(); end
  endtask
  initial begin
    reset_n = 1'b0; usbBusReset = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; toBufReady = 1'b1; fromBufValid = 1'b0; fromBufData = 16'h0000;
    shortPacket = 1'b0; wPol = 1'b0; rPol = 1'b0; qPol = 1'b0; aPol = 1'b0; ePol = 1'b0;
    rdWord = 16'h9abc; miscompares = 0; samples_checked = 0; diorCycles = 0;
    pops = 0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    // Reset state, write-only command register, reserved codes, unmapped place
    check(pinOut.dataOe, 1'b0, "data bus driven after reset");
    rdChk(ADDR_CMD, 32'h000000ff, "command register read");
    for (c = 2; c <= 5; c++) begin
      wr(ADDR_CMD, c);
      rdChk(ADDR_STATE, 32'h0, "state after reserved code");
    end
    check(pinOut.dataOe, 1'b0, "data bus driven by reserved code");
    rdChk(ADDR_CMD, 32'h000000ff, "command register read after write");
    rdChk(8'h80, 32'h0, "unmapped read");
    $display("Test reset and reserved codes done");
    // Target in, 16-bit with swap, counter of two, all polarities active high
    wPol <= 1'b1; rPol <= 1'b1; qPol <= 1'b1; aPol <= 1'b1; ePol <= 1'b1;
    wr(ADDR_CFG, 32'h1f5);
    wr(ADDR_MASK, 32'h1f);
    wr(ADDR_COUNT, 32'h2);
    check(pinOut.dreq, 1'b0, "request idle level");
    got.delete();
    wr(ADDR_CMD, {24'h0, CMD_TGT_IN});
    repeat (2) @(posedge sys_clk);
    check(pinOut.dreq, 1'b1, "request active level");
    ext.writeWord(16'h1234);
    ext.writeWord(16'habcd);
    waitWords(2);
    check({16'h0, got[0]}, 32'h3412, "first swapped word");
    check({16'h0, got[1]}, 32'hcdab, "second swapped word");
    repeat (3) @(posedge sys_clk);
    rdChk(ADDR_STATUS, 32'h1, "count done status");
    check(irq, 1'b1, "interrupt on count done");
    wr(ADDR_STATUS, 32'h1);
    @(posedge sys_clk);
    check(irq, 1'b0, "interrupt after clear");
    // Same with an 8-bit bus: swap has no effect, upper byte zero
    wr(ADDR_CFG, 32'h1f4);
    wr(ADDR_COUNT, 32'h1);
    got.delete();
    wr(ADDR_CMD, {24'h0, CMD_TGT_IN});
    ext.writeWord(16'h1234);
    waitWords(1);
    check({16'h0, got[0]}, 32'h0034, "narrow word");
    repeat (3) @(posedge sys_clk);
    rdChk(ADDR_STATUS, 32'h1, "narrow count done");
    wr(ADDR_STATUS, 32'h1);
    $display("Test target in done");
    // Target out in end-only mode, ended by the external end line
    fromBufValid <= 1'b1;
    fromBufData <= 16'h5678;
    wr(ADDR_CFG, 32'h1f3);
    wr(ADDR_CMD, {24'h0, CMD_TGT_OUT});
    repeat (3) @(posedge sys_clk);
    check(pinOut.dataOe, 1'b1, "data bus driven for out");
    ext.readWord(w16);
    check({16'h0, w16}, 32'h5678, "word read by controller");
    check(pops, 32'h1, "buffer word taken at strobe end");
    bus(1'b0, ADDR_STATE, 32'h0);
    check({29'h0, rd[4:2]}, 32'h2, "still running with end inactive");
    ext.endTransfer();
    repeat (4) @(posedge sys_clk);
    rdChk(ADDR_STATUS, 32'h2, "external end status");
    wr(ADDR_STATUS, 32'h2);
    // Same, ended by a short packet
    wr(ADDR_CMD, {24'h0, CMD_TGT_OUT});
    shortPacket <= 1'b1;
    @(posedge sys_clk);
    shortPacket <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdChk(ADDR_STATUS, 32'h4, "short packet end status");
    wr(ADDR_STATUS, 32'h4);
    // Same, ended by the stop command
    wr(ADDR_CMD, {24'h0, CMD_TGT_OUT});
    wr(ADDR_CMD, {24'h0, CMD_GEN_STOP});
    rdChk(ADDR_STATUS, 32'h8, "stop command status");
    wr(ADDR_STATUS, 32'h8);
    fromBufValid <= 1'b0;
    $display("Test target out done");
    // Target commands refused as initiator
    wr(ADDR_CFG, 32'h3f1);
    wr(ADDR_CMD, {24'h0, CMD_TGT_IN});
    repeat (2) @(posedge sys_clk);
    bus(1'b0, ADDR_STATE, 32'h0);
    check({29'h0, rd[4:2]}, 32'h0, "target command as initiator");
    check(pinOut.dreq, 1'b0, "no request as initiator");
    // Generic initiator in: device strobes, one word
    wr(ADDR_COUNT, 32'h1);
    got.delete();
    rdWord <= 16'h4321;
    wr(ADDR_CMD, {24'h0, CMD_INI_IN});
    waitWords(1);
    check({16'h0, got[0]}, 32'h4321, "initiator word");
    repeat (3) @(posedge sys_clk);
    rdChk(ADDR_STATUS, 32'h1, "initiator count done");
    wr(ADDR_STATUS, 32'h1);
    // Generic initiator out: device write strobe, one word taken from the buffer
    fromBufValid <= 1'b1;
    wr(ADDR_COUNT, 32'h1);
    wr(ADDR_CMD, {24'h0, CMD_INI_OUT});
    repeat (4) @(posedge sys_clk);
    check(pinOut.diow, 1'b1, "initiator write strobe active");
    repeat (16) @(posedge sys_clk);
    check(pops, 32'h2, "initiator word sent");
    rdChk(ADDR_STATUS, 32'h1, "initiator out done");
    wr(ADDR_STATUS, 32'h1);
    fromBufValid <= 1'b0;
    $display("Test initiator done");
    // Programmed-I/O read, 8-bit bus, timing mode 3, interrupt masked
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_CFG, 32'h61f0);
    rdWord <= 16'h9abc;
    got.delete();
    diorCycles = 0;
    wr(ADDR_CMD, {24'h0, CMD_PIO_READ});
    waitWords(1);
    check({16'h0, got[0]}, 32'h9abc, "full word on narrow bus");
    check(diorCycles, {24'h0, PIO_ACT_BASE} - 32'h3, "read strobe length");
    repeat (3) @(posedge sys_clk);
    rdChk(ADDR_STATUS, 32'h10, "read done status");
    check(irq, 1'b0, "masked interrupt");
    wr(ADDR_STATUS, 32'h10);
    $display("Test programmed read done");
    // Bus reset while the data bus is driven
    fromBufValid <= 1'b1;
    wr(ADDR_CFG, 32'h1f3);
    wr(ADDR_CMD, {24'h0, CMD_TGT_OUT});
    repeat (3) @(posedge sys_clk);
    usbBusReset <= 1'b1;
    @(posedge sys_clk);
    usbBusReset <= 1'b0;
    @(posedge sys_clk);
    check(pinOut.dataOe, 1'b0, "data bus after bus reset");
    rdChk(ADDR_CMD, 32'h000000ff, "command after bus reset");
    $display("Test bus reset done");
    check(ext.waitFails, 32'h0, "partner request wait");
    report_and_stop();
  end
endmodule // dma_cmd_ctrl_tb
`default_nettype wire
